// ==== irq_arbiter_pkg.sv ====
package irq_arbiter_pkg;

  // ----------------------------------------------------------------
  // Source count and widths
  // ----------------------------------------------------------------
  localparam int NUM_SRC   = 13;
  localparam int PC_W      = 15;
  localparam int SLOT_W    = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS   = 50;
  localparam int INSTR_CYCLE_NS    = 500;
  localparam int INSTR_CYCLE_CLKS  = (INSTR_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] DIV_LAST  = 4'(INSTR_CYCLE_CLKS - 1);
  localparam int ACK_INSTR_CYCLES  = 7;
  localparam logic [2:0] ACK_LAST  = 3'(ACK_INSTR_CYCLES - 1);
  localparam logic [3:0] ACK_SPAN  = 4'(ACK_INSTR_CYCLES);

  // ----------------------------------------------------------------
  // Addresses, slots and reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]    SERVICE_ADDR  = 15'h00ff;
  localparam logic [SLOT_W-1:0]  SLOT_TRAP     = 4'hf;
  localparam logic [SLOT_W-1:0]  SLOT_DEFAULT  = 4'h0;
  localparam logic [7:0]         VEC_BASE      = 8'he0;
  localparam logic [NUM_SRC-1:0] SRC_RESET     = 13'h0000;
  localparam logic               GIE_RESET     = 1'b0;

  // ----------------------------------------------------------------
  // Highest-ranked active source; bit 12 ranks highest, slot = bit + 1
  // ----------------------------------------------------------------
  function automatic logic [SLOT_W-1:0] highest_slot(input logic [NUM_SRC-1:0] act);
    logic [SLOT_W-1:0] slot;
    slot = SLOT_DEFAULT;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (act[i]) begin
        slot = SLOT_W'(i + 1);
      end
    end
    return slot;
  endfunction : highest_slot

  // Low byte of a slot's entry in the vector table
  function automatic logic [7:0] vector_offset(input logic [SLOT_W-1:0] slot);
    return VEC_BASE + {3'h0, slot, 1'b0};
  endfunction : vector_offset

endpackage : irq_arbiter_pkg

// ==== ack_link_if.sv ====
`timescale 1ns/1ps

// Link between the arbiter core and its acknowledge sequencer
interface ack_link_if;
  logic start;
  logic cycle_en;
  logic busy;
  logic push_stb;
  logic load_stb;

  modport ctrl (output start, output cycle_en, input busy, input push_stb, input load_stb);
  modport seq  (input start, input cycle_en, output busy, output push_stb, output load_stb);
endinterface : ack_link_if

// ==== ack_sequencer.sv ====
`timescale 1ns/1ps

module ack_sequencer
  import irq_arbiter_pkg::*;
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset,
  // Link to the arbiter core
  ack_link_if.seq   link
);

  typedef enum logic {IDLE, RUN} seq_state_t;

  seq_state_t state_q, state_d;
  logic [2:0] cnt_q,   cnt_d;

  // ----------------------------------------------------------------
  // Next state over the instruction cycles of an acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      IDLE: begin
        if (link.start) begin
          state_d = RUN;
          cnt_d   = 3'h0;
        end
      end
      RUN: begin
        if (link.cycle_en) begin
          if (cnt_q == ACK_LAST) begin
            state_d = IDLE;
          end else begin
            cnt_d = cnt_q + 3'h1;
          end
        end
      end
      default: state_d = IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= IDLE;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Strobes: push on the first cycle, vector load on the seventh
  assign link.busy     = (state_q == RUN);
  assign link.push_stb = (state_q == RUN) && link.cycle_en && (cnt_q == 3'h0);
  assign link.load_stb = (state_q == RUN) && link.cycle_en && (cnt_q == ACK_LAST);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start;
    link.start && !link.busy;
  endsequence

  chk_start_busy: assert property (@(posedge i_clock) disable iff (i_reset)
    s_start |=> link.busy && !link.load_stb)
    else $error("acknowledge did not begin after start");

  chk_push_once: assert property (@(posedge i_clock) disable iff (i_reset)
    link.push_stb |=> !link.push_stb [*8])
    else $error("return address pushed twice");

endmodule : ack_sequencer

// ==== vis_priority_select.sv ====
`timescale 1ns/1ps

module vis_priority_select
  import irq_arbiter_pkg::*;
(
  // Flags
  input  wire logic [NUM_SRC-1:0] i_pending,
  input  wire logic [NUM_SRC-1:0] i_enable,
  input  wire logic               i_trap_pending,
  // Selection
  output logic      [SLOT_W-1:0]  o_slot,
  output logic                    o_any_active
);

  logic [NUM_SRC-1:0] active;

  // Enabled and pending sources, trap above all, default below all
  always_comb begin
    active       = i_pending & i_enable;
    o_any_active = |active;
    if (i_trap_pending) begin
      o_slot = SLOT_TRAP;
    end else begin
      o_slot = highest_slot(active);
    end
  end

endmodule : vis_priority_select

// ==== vectored_interrupt_arbiter.sv ====
`timescale 1ns/1ps

module vectored_interrupt_arbiter
  import irq_arbiter_pkg::*;
(
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_reset,
  // Interrupt sources
  input  wire logic [NUM_SRC-1:0] i_src_event,
  input  wire logic               i_trap_event,
  // Instruction sequencer
  input  wire logic               i_instr_start,
  input  wire logic               i_skip_active,
  input  wire logic [PC_W-1:0]    i_next_addr,
  input  wire logic               i_return_from_interrupt,
  input  wire logic [PC_W-1:0]    i_pop_addr,
  input  wire logic               i_vector_select_instruction,
  // Control register access
  input  wire logic               i_pending_wr,
  input  wire logic [NUM_SRC-1:0] i_pending_wdata,
  input  wire logic               i_enable_wr,
  input  wire logic [NUM_SRC-1:0] i_enable_wdata,
  input  wire logic               i_processor_status_word_wr,
  input  wire logic               i_global_irq_enable_wdata,
  // Status
  output logic      [NUM_SRC-1:0] o_pending,
  output logic      [NUM_SRC-1:0] o_enable,
  output logic                    o_global_irq_enable,
  output logic                    o_trap_in_service,
  output logic                    o_irq_request,
  output logic                    o_ack_busy,
  output logic                    o_instr_cycle_en,
  // Stack and program counter
  output logic                    o_push_valid,
  output logic      [PC_W-1:0]    o_push_addr,
  output logic                    o_pc_load,
  output logic      [PC_W-1:0]    o_pc_value,
  // Vector select result
  output logic                    o_vis_valid,
  output logic      [SLOT_W-1:0]  o_vis_slot,
  output logic      [7:0]         o_vis_vector
);

  ack_link_if link ();

  logic [NUM_SRC-1:0] pending_q, pending_d;
  logic [NUM_SRC-1:0] enable_q,  enable_d;
  logic               gie_q,     gie_d;
  logic               trap_q,    trap_d;
  logic               nmi_q,     nmi_d;
  logic [PC_W-1:0]    ret_q,     ret_d;
  logic [3:0]         div_q,     div_d;
  logic               push_q,    push_d;
  logic               load_q,    load_d;
  logic [PC_W-1:0]    pc_q,      pc_d;
  logic               vis_q,     vis_d;
  logic [SLOT_W-1:0]  slot_q,    slot_d;
  logic [7:0]         vec_q,     vec_d;
  logic [3:0]         ack_en_q,  ack_en_d;
  logic [SLOT_W-1:0]  sel_slot;
  logic               any_active;
  logic               maskable_req;
  logic               accept;

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  vis_priority_select u_select (
    .i_pending      (pending_q),
    .i_enable       (enable_q),
    .i_trap_pending (trap_q),
    .o_slot         (sel_slot),
    .o_any_active   (any_active)
  );

  ack_sequencer u_ack (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .link    (link)
  );

  // ----------------------------------------------------------------
  // Instruction cycle divider
  // ----------------------------------------------------------------
  always_comb begin
    div_d = (div_q == DIV_LAST) ? 4'h0 : div_q + 4'h1;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_d;
    end
  end

  assign link.cycle_en = (div_q == DIV_LAST);

  // ----------------------------------------------------------------
  // Request and acceptance
  // ----------------------------------------------------------------
  assign maskable_req  = gie_q && !nmi_q && any_active;
  assign o_irq_request = trap_q || maskable_req;
  assign accept        = i_instr_start && !i_skip_active
                         && !link.busy && o_irq_request;
  assign link.start    = accept;

  // ----------------------------------------------------------------
  // Flags, enables and global enable
  // ----------------------------------------------------------------
  always_comb begin
    pending_d = i_pending_wr ? i_pending_wdata : pending_q;
    pending_d = pending_d | i_src_event;
    enable_d  = i_enable_wr ? i_enable_wdata : enable_q;
    trap_d    = (accept && trap_q) ? 1'b0 : trap_q;
    trap_d    = trap_d | i_trap_event;
    nmi_d     = nmi_q;
    if (i_return_from_interrupt) begin
      nmi_d = 1'b0;
    end
    if (accept && trap_q) begin
      nmi_d = 1'b1;
    end
    gie_d = gie_q;
    if (i_processor_status_word_wr) begin
      gie_d = i_global_irq_enable_wdata;
    end
    if (i_return_from_interrupt) begin
      gie_d = 1'b1;
    end
    if (accept) begin
      gie_d = 1'b0;
    end
    ret_d = accept ? i_next_addr : ret_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pending_q <= SRC_RESET;
      enable_q  <= SRC_RESET;
      gie_q     <= GIE_RESET;
      trap_q    <= 1'b0;
      nmi_q     <= 1'b0;
      ret_q     <= '0;
    end else begin
      pending_q <= pending_d;
      enable_q  <= enable_d;
      gie_q     <= gie_d;
      trap_q    <= trap_d;
      nmi_q     <= nmi_d;
      ret_q     <= ret_d;
    end
  end

  // ----------------------------------------------------------------
  // Stack, program counter and vector select outputs
  // ----------------------------------------------------------------
  always_comb begin
    push_d   = link.push_stb;
    load_d   = link.load_stb || i_return_from_interrupt;
    pc_d     = pc_q;
    if (i_return_from_interrupt) begin
      pc_d = i_pop_addr;
    end
    if (link.load_stb) begin
      pc_d = SERVICE_ADDR;
    end
    vis_d    = i_vector_select_instruction;
    slot_d   = i_vector_select_instruction ? sel_slot : slot_q;
    vec_d    = i_vector_select_instruction ? vector_offset(sel_slot) : vec_q;
    ack_en_d = ack_en_q;
    if (accept) begin
      ack_en_d = 4'h0;
    end else if (link.busy && link.cycle_en) begin
      ack_en_d = ack_en_q + 4'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      push_q   <= 1'b0;
      load_q   <= 1'b0;
      pc_q     <= '0;
      vis_q    <= 1'b0;
      slot_q   <= SLOT_DEFAULT;
      vec_q    <= VEC_BASE;
      ack_en_q <= 4'h0;
    end else begin
      push_q   <= push_d;
      load_q   <= load_d;
      pc_q     <= pc_d;
      vis_q    <= vis_d;
      slot_q   <= slot_d;
      vec_q    <= vec_d;
      ack_en_q <= ack_en_d;
    end
  end

  // Output wiring
  assign o_pending           = pending_q;
  assign o_enable            = enable_q;
  assign o_global_irq_enable = gie_q;
  assign o_trap_in_service   = nmi_q;
  assign o_ack_busy          = link.busy;
  assign o_instr_cycle_en    = link.cycle_en;
  assign o_push_valid        = push_q;
  assign o_push_addr         = ret_q;
  assign o_pc_load           = load_q;
  assign o_pc_value          = pc_q;
  assign o_vis_valid         = vis_q;
  assign o_vis_slot          = slot_q;
  assign o_vis_vector        = vec_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_accept;
    accept;
  endsequence

  sequence s_return;
    i_return_from_interrupt && !accept && !link.load_stb;
  endsequence

  chk_service_addr: assert property (
    link.load_stb |=> o_pc_load && (o_pc_value == SERVICE_ADDR))
    else $error("service address not loaded");

  chk_ack_span: assert property (
    link.load_stb |-> (ack_en_q == ACK_SPAN - 4'h1))
    else $error("acknowledge length wrong");

  chk_gie_clear: assert property (
    s_accept |=> !o_global_irq_enable)
    else $error("global enable not cleared on acknowledge");

  chk_mask_gate: assert property (
    s_accept |-> trap_q || (gie_q && !nmi_q && any_active))
    else $error("maskable accepted while gated");

  chk_trap_first: assert property (
    s_accept ##0 trap_q |=> o_trap_in_service)
    else $error("trap not taken first");

  chk_skip_wait: assert property (
    accept |-> i_instr_start && !i_skip_active)
    else $error("accepted outside instruction start");

  chk_push_addr: assert property (
    s_accept |=> (o_push_addr == $past(i_next_addr)))
    else $error("wrong return address pushed");

  chk_push_timely: assert property (
    s_accept |-> ##[1:10] link.push_stb ##1 o_push_valid)
    else $error("return address push missing");

  chk_event_sets: assert property (
    |i_src_event |=> ((o_pending & $past(i_src_event)) == $past(i_src_event)))
    else $error("event did not set pending");

  chk_return_restore: assert property (
    s_return |=> o_global_irq_enable && o_pc_load
      && (o_pc_value == $past(i_pop_addr)))
    else $error("return did not restore state");

  chk_vis_default: assert property (
    i_vector_select_instruction && !trap_q && !any_active
      |=> o_vis_valid && (o_vis_slot == SLOT_DEFAULT) && (o_vis_vector == VEC_BASE))
    else $error("default vector not chosen");

  chk_reset_clear: assert property (@(posedge i_clock) disable iff (1'b0)
    i_reset |=> (o_pending == SRC_RESET) && (o_enable == SRC_RESET) && !o_global_irq_enable)
    else $error("reset left flags set");

endmodule : vectored_interrupt_arbiter

// ==== instr_seq_model.sv ====
`timescale 1ns/1ps

module instr_seq_model
  import irq_arbiter_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clock,
  input  wire logic            i_reset,
  // Bench control and arbiter status
  input  wire logic            i_run,
  input  wire logic            i_cycle_en,
  input  wire logic            i_ack_busy,
  input  wire logic            i_pc_load,
  input  wire logic [PC_W-1:0] i_pc_value,
  // Instruction boundary and address
  output logic                 o_instr_start,
  output logic      [PC_W-1:0] o_next_addr
);
  logic            start_d, start_q;
  logic [PC_W-1:0] pc_d, pc_q;

  // Next state: one start per tick, stalled while the arbiter acknowledges
  always_comb begin
    start_d = i_cycle_en & i_run & ~i_ack_busy;
    pc_d    = pc_q;
    if (i_pc_load) begin
      pc_d = i_pc_value;
    end else if (start_q) begin
      pc_d = pc_q + 15'h0001;
    end
  end

  // State registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      start_q <= 1'b0;
      pc_q    <= 15'h0100;
    end else begin
      start_q <= start_d;
      pc_q    <= pc_d;
    end
  end

  assign o_instr_start = start_q;
  assign o_next_addr   = pc_q;
endmodule : instr_seq_model

// ==== tb.sv ====
`timescale 1ns/1ps

module tb;
  import irq_arbiter_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              i_clock = 1'b0;
  logic              i_reset = 1'b1;
  logic [12:0]       src_event, pend_wdata, en_wdata, pending, enable;
  logic              trap_event, skip, return_from_interrupt, vis, pend_wr, en_wr, psw_wr, gie_wdata, run;
  logic [PC_W-1:0]   pop_addr, next_addr, push_addr, pc_value, start_addr;
  logic              global_irq_enable, tis, irq_req, busy, cyc_en, push_valid, pc_load, vis_valid;
  logic              instr_start, prev_start;
  logic [3:0]        vis_slot;
  logic [7:0]        vis_vector;
  int                mismatches = 0;
  int                comparisons = 0;

  always #25 i_clock = ~i_clock;

  vectored_interrupt_arbiter i_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_src_event(src_event),
    .i_trap_event(trap_event), .i_instr_start(instr_start), .i_skip_active(skip),
    .i_next_addr(next_addr), .i_return_from_interrupt(return_from_interrupt), .i_pop_addr(pop_addr),
    .i_vector_select_instruction(vis), .i_pending_wr(pend_wr),
    .i_pending_wdata(pend_wdata), .i_enable_wr(en_wr), .i_enable_wdata(en_wdata),
    .i_processor_status_word_wr(psw_wr), .i_global_irq_enable_wdata(gie_wdata),
    .o_pending(pending), .o_enable(enable), .o_global_irq_enable(global_irq_enable),
    .o_trap_in_service(tis), .o_irq_request(irq_req), .o_ack_busy(busy),
    .o_instr_cycle_en(cyc_en), .o_push_valid(push_valid), .o_push_addr(push_addr),
    .o_pc_load(pc_load), .o_pc_value(pc_value), .o_vis_valid(vis_valid),
    .o_vis_slot(vis_slot), .o_vis_vector(vis_vector));

  instr_seq_model i_seq (
    .i_clock(i_clock), .i_reset(i_reset), .i_run(run), .i_cycle_en(cyc_en),
    .i_ack_busy(busy), .i_pc_load(pc_load), .i_pc_value(pc_value),
    .o_instr_start(instr_start), .o_next_addr(next_addr));

  // Remember the boundary that an acknowledge was taken at
  always @(posedge i_clock) begin
    prev_start <= instr_start;
    if (instr_start) start_addr <= next_addr;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic fail_hang;
    mismatches++;
    $display("[ERR] t=%0t wait bound used up seen=0 exp=1", $time);
    tally_and_finish();
  endtask : fail_hang

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick

  // Write pending (0), enable (1) or global enable (2)
  task automatic wr(input int sel, input logic [12:0] v);
    pend_wr = (sel == 0);
    en_wr = (sel == 1);
    psw_wr = (sel == 2);
    pend_wdata = v;
    en_wdata = v;
    gie_wdata = v[0];
    tick(1);
    {pend_wr, en_wr, psw_wr} = 3'h0;
    // Idle edge so back-to-back writes never re-raise a strobe at once
    tick(1);
  endtask : wr

  task automatic ev(input logic [12:0] v, input logic trap);
    src_event = v;
    trap_event = trap;
    tick(1);
    src_event = 13'h0000;
    trap_event = 1'b0;
  endtask : ev

  task automatic do_vis(input logic [3:0] slot);
    vis = 1'b1;
    tick(1);
    vis = 1'b0;
    check(vis_valid, 1);
    check(vis_slot, slot);
    check(vis_vector, 8'he0 + {3'h0, slot, 1'b0});
  endtask : do_vis

  task automatic return_from_interrupt_to(input logic [PC_W-1:0] a);
    pop_addr = a;
    return_from_interrupt = 1'b1;
    tick(1);
    return_from_interrupt = 1'b0;
    check(global_irq_enable, 1);
    check(pc_load, 1);
    check(pc_value, a);
  endtask : return_from_interrupt_to

  // Wait for acceptance, then follow the whole acknowledge
  task automatic ack_seq(input int bound);
    int   n;
    logic pushed;
    n = 0;
    pushed = 1'b0;
    while (busy !== 1'b1 && n < bound) begin
      tick(1);
      n++;
    end
    if (busy !== 1'b1) fail_hang();
    check(prev_start, 1);
    check(global_irq_enable, 0);
    n = 0;
    while (pc_load !== 1'b1 && n < 100) begin
      if (push_valid === 1'b1) begin
        pushed = 1'b1;
        check(push_addr, start_addr);
      end
      tick(1);
      n++;
    end
    if (pc_load !== 1'b1) fail_hang();
    check(pushed, 1);
    check(pc_value, 16'h00ff);
    check(n >= 6 * INSTR_CYCLE_CLKS + 1 && n <= 7 * INSTR_CYCLE_CLKS, 1);
  endtask : ack_seq

  task automatic clean;
    run = 1'b0;
    wr(0, 13'h0000);
    wr(1, 13'h0000);
    return_from_interrupt_to(15'h0200);
    wr(2, 13'h0000);
  endtask : clean

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    int n;
    check(pending, 0);
    check(enable, 0);
    check(global_irq_enable, 0);
    check(vis_vector, 8'he0);
    // Instruction-cycle tick spacing
    n = 0;
    while (cyc_en !== 1'b1 && n < 12) begin
      tick(1);
      n++;
    end
    if (cyc_en !== 1'b1) fail_hang();
    tick(INSTR_CYCLE_CLKS - 1);
    check(cyc_en, 0);
    tick(1);
    check(cyc_en, 1);
  endtask : t_reset

  // Reset in mid-run with every source pending flag, every enable and the global enable set
  task automatic t_mid_reset;
    wr(1, 13'h1fff);
    ev(13'h1fff, 1'b0);
    wr(2, 13'h0001);
    check(irq_req, 1);
    i_reset = 1'b1;
    tick(2);
    i_reset = 1'b0;
    tick(1);
    check(pending, 0);
    check(enable, 0);
    check(global_irq_enable, 0);
    check(irq_req, 0);
  endtask : t_mid_reset

  task automatic t_flags;
    ev(13'h1555, 1'b0);
    check(pending, 13'h1555);
    wr(1, 13'h0aaa);
    check(enable, 13'h0aaa);
    check(irq_req, 0);
    wr(0, 13'h0000);
    check(pending, 0);
  endtask : t_flags

  task automatic t_vis_all;
    wr(1, 13'h1fff);
    for (int i = 0; i < 13; i++) begin
      wr(0, 13'(1 << i));
      do_vis(4'(i + 1));
    end
    wr(0, 13'h0208);
    do_vis(4'ha);
    wr(1, 13'h0000);
    do_vis(4'h0);
    wr(0, 13'h0000);
  endtask : t_vis_all

  task automatic t_late_enable;
    wr(2, 13'h0001);
    ev(13'h0008, 1'b0);
    check(irq_req, 0);
    wr(1, 13'h0008);
    check(irq_req, 1);
    clean();
  endtask : t_late_enable

  task automatic t_nest;
    wr(1, 13'h0020);
    ev(13'h0020, 1'b0);
    wr(2, 13'h0001);
    run = 1'b1;
    ack_seq(25);
    check(pending, 13'h0020);
    tick(30);
    check(busy, 0);
    return_from_interrupt_to(15'h1234);
    ack_seq(12);
    clean();
  endtask : t_nest

  task automatic t_skip;
    wr(1, 13'h0001);
    ev(13'h0001, 1'b0);
    wr(2, 13'h0001);
    skip = 1'b1;
    run = 1'b1;
    tick(30);
    check(busy, 0);
    skip = 1'b0;
    ack_seq(12);
    clean();
  endtask : t_skip

  task automatic t_trap;
    ev(13'h0000, 1'b1);
    wr(0, 13'h1000);
    wr(1, 13'h1000);
    do_vis(4'hf);
    run = 1'b1;
    ack_seq(25);
    check(tis, 1);
    wr(2, 13'h0001);
    check(global_irq_enable, 1);
    check(irq_req, 0);
    tick(30);
    check(busy, 0);
    return_from_interrupt_to(15'h0400);
    check(tis, 0);
    ack_seq(12);
    clean();
  endtask : t_trap

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {src_event, pend_wdata, en_wdata} = '0;
    {trap_event, skip, return_from_interrupt, vis, pend_wr, en_wr, psw_wr, gie_wdata, run} = '0;
    pop_addr = 15'h0000;
    tick(5);
    i_reset = 1'b0;
    tick(1);
    t_reset();
    t_flags();
    t_vis_all();
    t_late_enable();
    t_nest();
    t_skip();
    t_trap();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : tb
